/* src/ussc_consts.svh */
// constants for the usb suspend state control block
// assumes a 10 mhz core clock
`ifndef USSC_CONSTS_SVH
`define USSC_CONSTS_SVH
`define USSC_CLK_MHZ 10
`define USSC_EXT_RST_MIN_US 15
// least time in whole cycles: microseconds times clock mhz
`define USSC_EXT_RST_CYC (`USSC_EXT_RST_MIN_US * `USSC_CLK_MHZ)
`define USSC_CNT_W 8
`define USSC_CNT_RST 8'h00
`endif

/* src/ussc_pkg.sv */
// types for the usb suspend state control block
// constants live in ussc_consts.svh
package ussc_pkg;
	typedef enum logic [1:0] {
		ussc_unconfigured,
		ussc_active,
		ussc_suspended
	} ussc_state_e;

	// usb-side event strobes from the function controller
	typedef struct packed {
		logic suspend_det;
		logic resume_det;
		logic resume_gen;
		logic bus_reset_det;
		logic configured;
	} ussc_usb_ev_s;

	// modem control, true level (1 = asserted)
	typedef struct packed {
		logic cts;
		logic dsr;
		logic dcd;
		logic ri;
	} ussc_modem_in_s;

	typedef struct packed {
		logic rts;
		logic dtr;
	} ussc_modem_out_s;

	// two-flop synchroniser state
	typedef struct packed {
		logic s1;
		logic s2;
	} ussc_sync_s;
endpackage : ussc_pkg

/* src/ussc_sync.sv */
// two-flop level synchroniser with clock enable
// assumes the async input may change at any time
`timescale 1ns/1ns
module ussc_sync #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic d,
	output logic q
);
	ussc_pkg::ussc_sync_s st, next_st;

	// first stage feeds only the second stage
	always_comb begin
		next_st = st;
		if (ce) begin
			next_st.s1 = d;
			next_st.s2 = st.s1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st <= {RST_VAL, RST_VAL};
		end else begin
			st <= next_st;
		end
	end

	assign q = st.s2;
endmodule : ussc_sync

/* src/ussc_top.sv */
// usb suspend state control: suspend pins, reset pin, bus power sense
// assumes usb events are one-cycle strobes synchronous to clk
// assumes pin levels arrive already buffered from the pads
// assumes ce gates every register of the block, synchronisers too
// Notes on behaviour
// RQ1 - an external low pulse on the reset pin of at least 15 us is a full reset.
// RQ2 - the reset pin is driven only open-drain, low while internal reset is on.
// RQ3 - a high bus-power sense level means attached, low means detached.
// RQ4 - cts, dsr, dcd and ri pins are active low.
// RQ5 - rts and dtr pins are driven active low.
// RQ6 - the active-high suspend output is high while suspended.
// RQ7 - the active-low suspend output is low while suspended.
// RQ8 - detected suspend signalling moves the block into suspend.
// RQ9 - after any reset both suspend outputs stay asserted until configured.
// RQ10 - resume, bus reset or device reset take the block out of suspend.
// RQ11 - on leaving suspend both suspend outputs are deasserted; after a device reset the code floats them high, then asserts them.
// RQ12 - during reset both suspend outputs are released and float high.
// RQ13 - reset pin and bus-power sense are synchronised before use.
`timescale 1ns/1ns
`include "ussc_consts.svh"
module ussc_top (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic por_active,
	input wire logic rst_pin_in,
	output logic rst_pin_out,
	output logic rst_pin_oe,
	input wire logic vbus_sense,
	input wire ussc_pkg::ussc_usb_ev_s usb_ev,
	input wire logic [3:0] modem_pins_n,
	input wire ussc_pkg::ussc_modem_out_s modem_req,
	output ussc_pkg::ussc_modem_in_s modem_in,
	output logic [1:0] modem_pins_n_out,
	output logic suspend_out,
	output logic suspend_oe,
	output logic suspend_n_out,
	output logic suspend_n_oe,
	output logic bus_attached,
	output logic device_reset
);
	// whole block state, registered as one image
	typedef struct packed {
		ussc_pkg::ussc_state_e state;
		logic [`USSC_CNT_W-1:0] low_cnt;
		logic ext_reset;
		logic in_reset; // registered copy of any_reset
		logic rst_out;
		logic rst_oe;
		logic susp;
		logic susp_oe;
		logic susp_n;
		logic susp_n_oe;
		logic attached;
		ussc_pkg::ussc_modem_in_s min;
		logic [1:0] mout_n;
	} ussc_top_s;

	ussc_top_s st, next_st;
	logic rst_pin_sync;
	logic vbus_sync;
	logic any_reset;

	// reset pin idles high; a released pin reads high
	ussc_sync #(.RST_VAL(1'b1)) u_rst_sync ( // RQ13
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.d(rst_pin_in),
		.q(rst_pin_sync)
	);

	ussc_sync #(.RST_VAL(1'b0)) u_vbus_sync ( // RQ13
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.d(vbus_sense),
		.q(vbus_sync)
	);

	// device reset: internal monitor or a qualified external pulse
	assign any_reset = por_active || st.ext_reset;

	// resume, wake-up or bus reset end a suspend
	function automatic logic exit_req(
		input ussc_pkg::ussc_usb_ev_s ev
	);
		exit_req = ev.resume_det || ev.resume_gen || ev.bus_reset_det;
	endfunction : exit_req

	// suspend pins read asserted in every state except active
	function automatic logic pins_asserted(
		input ussc_pkg::ussc_state_e s
	);
		pins_asserted = s != ussc_pkg::ussc_active;
	endfunction : pins_asserted

	// low time has reached the qualifying length
	function automatic logic low_full(
		input logic [`USSC_CNT_W-1:0] c
	);
		low_full = c == `USSC_CNT_W'(`USSC_EXT_RST_CYC);
	endfunction : low_full

	// next suspend state; any device reset wins over usb events
	function automatic ussc_pkg::ussc_state_e step_state(
		input ussc_pkg::ussc_state_e s,
		input ussc_pkg::ussc_usb_ev_s ev,
		input logic rst
	);
		step_state = s;
		if (rst) begin
			step_state = ussc_pkg::ussc_unconfigured; // RQ9 RQ10
		end else begin
			case (s)
			ussc_pkg::ussc_unconfigured: begin
				if (ev.configured)
					step_state = ussc_pkg::ussc_active; // RQ9
			end
			ussc_pkg::ussc_active: begin
				if (ev.suspend_det)
					step_state = ussc_pkg::ussc_suspended; // RQ8
			end
			ussc_pkg::ussc_suspended: begin
				// exit wins over a fresh suspend in the same cycle
				if (exit_req(ev))
					step_state = ussc_pkg::ussc_active; // RQ10
			end
			default: step_state = ussc_pkg::ussc_unconfigured;
			endcase
		end
	endfunction : step_state

	// low-active modem pins to true levels
	function automatic ussc_pkg::ussc_modem_in_s pins_to_true(
		input logic [3:0] p
	);
		pins_to_true = ussc_pkg::ussc_modem_in_s'(~p);
	endfunction : pins_to_true

	// true-level requests to low-active pin levels
	function automatic logic [1:0] req_to_pins(
		input ussc_pkg::ussc_modem_out_s r
	);
		req_to_pins = ~{r.rts, r.dtr};
	endfunction : req_to_pins

	// one next-state image; ce low leaves every field as it stands
	always_comb begin
		next_st = st;
		if (ce) begin
			// reset pin low time, saturating; short glitches never qualify
			if (!rst_pin_sync) begin
				if (!low_full(st.low_cnt))
					next_st.low_cnt = st.low_cnt + `USSC_CNT_W'(1);
			end else begin
				next_st.low_cnt = `USSC_CNT_RST;
			end
			// held until the pin is released again
			next_st.ext_reset = !rst_pin_sync &&
				low_full(next_st.low_cnt); // RQ1

			// only the internal monitor pulls the pin; an external pulse
			// driving it too would hold the device in reset for good
			next_st.rst_out = 1'b0; // RQ2
			next_st.rst_oe = por_active; // RQ2

			// pin levels handed on, one register deep
			next_st.attached = vbus_sync; // RQ3
			next_st.min = pins_to_true(modem_pins_n); // RQ4
			next_st.mout_n = req_to_pins(modem_req); // RQ5

			// suspend state machine and the visible reset flag
			next_st.state = step_state(st.state, usb_ev, any_reset);
			next_st.in_reset = any_reset;

			// outputs float during reset, asserted otherwise if not active
			if (any_reset) begin
				next_st.susp = 1'b1; // RQ12
				next_st.susp_oe = 1'b0; // RQ12
				next_st.susp_n = 1'b1; // RQ12
				next_st.susp_n_oe = 1'b0; // RQ12
			end else begin
				next_st.susp_oe = 1'b1;
				next_st.susp_n_oe = 1'b1;
				next_st.susp =
					pins_asserted(next_st.state); // RQ6 RQ9 RQ11
				next_st.susp_n =
					!pins_asserted(next_st.state); // RQ7 RQ9 RQ11
			end
		end
	end

	// async reset acts as the device reset: outputs float high
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st.state <= ussc_pkg::ussc_unconfigured;
			st.low_cnt <= `USSC_CNT_RST;
			st.ext_reset <= 1'b0;
			st.in_reset <= 1'b1;
			st.rst_out <= 1'b0;
			st.rst_oe <= 1'b0;
			st.susp <= 1'b1;
			st.susp_oe <= 1'b0; // RQ12
			st.susp_n <= 1'b1;
			st.susp_n_oe <= 1'b0; // RQ12
			st.attached <= 1'b0;
			st.min <= '0;
			st.mout_n <= 2'h3;
		end else begin
			st <= next_st;
		end
	end

	// outputs come straight from the state register
	assign rst_pin_out = st.rst_out;
	assign rst_pin_oe = st.rst_oe;
	assign suspend_out = st.susp;
	assign suspend_oe = st.susp_oe;
	assign suspend_n_out = st.susp_n;
	assign suspend_n_oe = st.susp_n_oe;
	assign bus_attached = st.attached;
	assign modem_in = st.min;
	assign modem_pins_n_out = st.mout_n;
	assign device_reset = st.in_reset;
endmodule : ussc_top

/* tb/ussc_checker.sv */
// port assertions for the suspend control block
// assumes it is bound onto every ussc_top
`timescale 1ns/1ns
module ussc_checker (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic por_active,
	input wire ussc_pkg::ussc_usb_ev_s usb_ev,
	input wire logic [3:0] modem_pins_n,
	input wire ussc_pkg::ussc_modem_in_s modem_in,
	input wire logic suspend_out,
	input wire logic suspend_oe,
	input wire logic suspend_n_out,
	input wire logic rst_pin_oe,
	input wire logic device_reset
);
	logic seen;
	logic go;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// set once configured; pins alone cannot tell suspend from unconfigured
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) seen <= 1'b0;
		else if (!suspend_oe) seen <= 1'b0;
		else if (!suspend_out) seen <= 1'b1;
	end
	assign go = ce && suspend_oe && !por_active && !device_reset;
	// suspend pins, reset pin, modem inputs
	susp_pair_a: assert property (suspend_oe
		|-> suspend_out != suspend_n_out) else $error("pair");
	rst_drive_a: assert property (ce
		|=> rst_pin_oe == $past(por_active)) else $error("drive");
	por_float_a: assert property (ce && por_active
		|=> !suspend_oe && suspend_out && suspend_n_out) else $error("por");
	rst_float_a: assert property ($rose(device_reset)
		|-> ##[0:1] !suspend_oe) else $error("float");
	enter_susp_a: assert property (go && seen && !suspend_out
		&& usb_ev.suspend_det |=> suspend_out) else $error("enter");
	exit_susp_a: assert property (go && seen && suspend_out &&
		(usb_ev.resume_det || usb_ev.resume_gen || usb_ev.bus_reset_det)
		|=> !suspend_out) else $error("exit");
	cfg_hold_a: assert property (go && !seen && suspend_out
		&& !usb_ev.configured |=> suspend_out) else $error("hold");
	modem_inv_a: assert property (ce && resetn
		|=> modem_in == ~$past(modem_pins_n)) else $error("modem");
	cover property (seen && usb_ev.suspend_det);
	cover property (ce && por_active);
	cover property (device_reset);
endmodule : ussc_checker
bind ussc_top ussc_checker ussc_checker_inst (.clk, .resetn, .ce,
	.por_active, .usb_ev, .modem_pins_n, .modem_in, .suspend_out,
	.suspend_oe, .suspend_n_out, .rst_pin_oe, .device_reset);

/* tb/ussc_partner.sv */
// partner: usb event strobes and the pulled-up reset line
// assumes tasks are called just after a rising edge
`timescale 1ns/1ns
module ussc_partner (
	input wire logic clk,
	input wire logic rst_pin_oe,
	output ussc_pkg::ussc_usb_ev_s usb_ev = 5'h00,
	output logic rst_pin_in
);
	logic low = 1'b0;
	// open-drain line, high when nobody pulls
	assign rst_pin_in = !(rst_pin_oe || low);
	// strobe then idle, so no double drive in one step
	task send(input logic [4:0] e);
		usb_ev <= e;
		@(posedge clk);
		usb_ev <= 5'h00;
		@(posedge clk);
	endtask : send
	task pulse(input int n);
		low <= 1'b1;
		repeat (n) @(posedge clk);
		low <= 1'b0;
	endtask : pulse
endmodule : ussc_partner

/* tb/usb_suspend_state_control_bench.sv */
// bench: table of usb events, then internal and pin resets
// assumes the partner drives usb events and the reset line
`timescale 1ns/1ns
module usb_suspend_state_control_bench;
	logic clk = 1'b0, resetn = 1'b0, por = 1'b0, vb = 1'b0;
	logic [3:0] pins = 4'h0;
	logic [1:0] req = 2'h0, mo;
	logic pi, ro, oe, so, soe, sno, snoe, att, dr, s;
	ussc_pkg::ussc_usb_ev_s ev;
	ussc_pkg::ussc_modem_in_s mi;
	int bad_count = 0, checks = 0;
	// event, pins, request, vbus, suspended
	logic [12:0] rows [12] = '{13'h01a6, 13'h1059, 13'h10ff, 13'h0800,
		13'h1037, 13'h04c8, 13'h109f, 13'h0260, 13'h0816, 13'h0128,
		13'h184f, 13'h1280};
	always #50 clk = ~clk;
	ussc_top ussc_top_inst (.clk, .resetn, .ce(1'b1), .por_active(por),
		.rst_pin_in(pi), .rst_pin_out(ro), .rst_pin_oe(oe), .vbus_sense(vb),
		.usb_ev(ev), .modem_pins_n(pins), .modem_req(req), .modem_in(mi),
		.modem_pins_n_out(mo), .suspend_out(so), .suspend_oe(soe),
		.suspend_n_out(sno), .suspend_n_oe(snoe), .bus_attached(att),
		.device_reset(dr));
	ussc_partner ussc_partner_inst (.clk, .rst_pin_oe(oe), .usb_ev(ev),
		.rst_pin_in(pi));
	task chk(input string n, input logic [3:0] e, input logic [3:0] g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task stop_test;
		if (bad_count == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : stop_test
	// watchdog, far past the run length
	initial begin
		repeat (3000) @(posedge clk);
		bad_count++;
		stop_test();
	end
	// reset, table, then internal and pin resets
	initial begin
		repeat (4) @(negedge clk);
		chk("rst", 4'h3, {soe, snoe, so, sno});
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		repeat (2) @(negedge clk);
		chk("start", 4'hc, {soe, so, sno, dr});
		@(posedge clk);
		foreach (rows[i]) begin
			{pins, req, vb, s} <= rows[i][7:0];
			ussc_partner_inst.send(rows[i][12:8]);
			repeat (2) @(negedge clk);
			chk("sus", {1'b1, s, !s, 1'b1}, {soe, so, sno, snoe});
			chk("out", {~req, vb, 1'b0}, {mo, att, 1'b0});
			chk("min", ~pins, mi);
			@(posedge clk);
		end
		por <= 1'b1;
		repeat (2) @(negedge clk);
		chk("por", 4'h6, {soe, so, sno, pi});
		chk("pout", 4'h1, {2'h0, ro, oe});
		@(posedge clk);
		por <= 1'b0;
		repeat (2) @(negedge clk);
		chk("unc", 4'hd, {soe, so, sno, pi});
		@(posedge clk);
		// one cycle short of the limit: no reset may show at all
		ussc_partner_inst.pulse(149);
		repeat (8) begin
			@(negedge clk);
			chk("short", 4'h0, {3'h0, dr});
		end
		@(posedge clk);
		// count qualifies at the last low edge, two stages after the pin
		ussc_partner_inst.pulse(152);
		@(negedge clk);
		chk("sync", 4'h1, {2'h0, dr, soe});
		@(negedge clk);
		chk("long", 4'h2, {2'h0, dr, soe});
		repeat (10) @(negedge clk);
		chk("back", 4'h6, {1'b0, soe, so, dr});
		stop_test();
	end
endmodule : usb_suspend_state_control_bench
